// ---- core/cwc_checker.sv ----
// cec receive waveform checker with apb register access
// Functional notes
// - latest rise for a logical 0 is 56 sample_clock periods plus the 3-bit setting.
// - earliest rise for a logical 0 is 43 sample_clock periods minus the 3-bit setting.
// - latest rise for a logical 1 is 26 sample_clock periods plus the 3-bit setting.
// - earliest rise for a logical 1 is 13 sample_clock periods minus the 3-bit setting.
// - one enable bit turns detection on at 1 and off at 0; all four settings are read/write.
`timescale 1ns/1ps
module cwc_checker (
    input  wire logic        pclk,         // system clock, 25 MHz
    input  wire logic        presetn,      // async reset, active low
    input  wire logic        psel,         // apb select
    input  wire logic        penable,      // apb access phase
    input  wire logic        pwrite,       // apb direction
    input  wire logic [11:0] paddr,        // apb byte address
    input  wire logic [31:0] pwdata,       // apb write data
    output logic      [31:0] prdata,       // apb read data
    output logic             pready,       // apb ready
    output logic             pslverr,      // apb error, unmapped address
    input  wire logic        sample_clock, // sampling tick, async
    input  wire logic        cec_in,       // bus line level, async
    output logic             wave_err,     // one-cycle pulse per bad bit
    output logic             irq           // level interrupt
);
    import cwc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        cwc_state_t  fsm;
        logic [31:0] limits;
        logic [1:0]  status;
        logic [1:0]  mask;
        logic [7:0]  count;
        logic [7:0]  last_rise;
        logic        tick_d;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic        err;
        logic        irq;
    } cwc_state_s_t;
    cwc_state_s_t st, next_st;

    logic line;
    logic tick;
    logic tick_rise;
    logic [7:0] zero_hi;
    logic [7:0] zero_lo;
    logic [7:0] one_hi;
    logic [7:0] one_lo;
    logic in_zero;
    logic in_one;
    logic setup;
    logic mapped;
    logic [1:0] ev;

    cwc_sync u_line (.pclk(pclk), .presetn(presetn), .din(cec_in), .dout(line));
    cwc_sync u_tick (.pclk(pclk), .presetn(presetn), .din(sample_clock), .dout(tick));

    ////////////////////////////////////////////////////////////////////////////
    assign tick_rise = tick & ~st.tick_d;
    assign zero_hi = ZERO_LATEST_BASE + {5'h0, st.limits[ZERO_LATEST_LSB +: 3]};
    assign zero_lo = ZERO_EARLY_BASE - {5'h0, st.limits[ZERO_EARLY_LSB +: 3]};
    assign one_hi  = ONE_LATEST_BASE + {5'h0, st.limits[ONE_LATEST_LSB +: 3]};
    assign one_lo  = ONE_EARLY_BASE - {5'h0, st.limits[ONE_EARLY_LSB +: 3]};
    assign in_zero = (st.count >= zero_lo) && (st.count <= zero_hi);
    assign in_one  = (st.count >= one_lo) && (st.count <= one_hi);
    assign setup   = psel && !penable;
    assign mapped  = (paddr == LIMITS_ADDR) || (paddr == STATUS_ADDR) ||
                     (paddr == MASK_ADDR) || (paddr == MEASURE_ADDR);

    always_comb begin
        next_st        = st;
        next_st.tick_d = tick;
        next_st.err    = 1'b0;
        ev             = 2'h0;
        // measure low time in sample_clock ticks; saturate so a stuck line stays wrong
        case (st.fsm)
            CWC_IDLE: begin
                if (!line) begin
                    next_st.fsm   = CWC_LOW;
                    next_st.count = 8'h00;
                end
            end
            CWC_LOW: begin
                if (line) begin
                    next_st.fsm        = CWC_IDLE;
                    next_st.last_rise  = st.count;
                    ev[ST_BIT_DONE]    = 1'b1;
                    if (st.limits[ENABLE_BIT] && !in_zero && !in_one) begin
                        ev[ST_WAVE_ERR] = 1'b1;
                        next_st.err     = 1'b1;
                    end
                end else if (tick_rise && st.count != COUNT_MAX) begin
                    next_st.count = st.count + 8'h01;
                end
            end
            default: next_st.fsm = CWC_IDLE;
        endcase
        // apb: one wait-free access phase; reads return data registered at setup
        next_st.ready  = setup;
        next_st.slverr = setup && !mapped;
        if (setup && !pwrite) begin
            if (paddr == LIMITS_ADDR) begin
                next_st.rdata = st.limits;
            end else if (paddr == STATUS_ADDR) begin
                // include this edge's event: the access edge clears it, so it must be seen now
                next_st.rdata = {30'h0, st.status | ev};
            end else if (paddr == MASK_ADDR) begin
                next_st.rdata = {30'h0, st.mask};
            end else if (paddr == MEASURE_ADDR) begin
                next_st.rdata = {24'h0, st.last_rise};
            end else begin
                next_st.rdata = 32'h0;
            end
        end
        // status read clears on the completing edge; a same-cycle event still sets
        if (psel && penable && st.ready && !pwrite && paddr == STATUS_ADDR) begin
            next_st.status = ev;
        end else begin
            next_st.status = st.status | ev;
        end
        if (psel && penable && st.ready && pwrite) begin
            if (paddr == LIMITS_ADDR) begin
                next_st.limits = pwdata & LIMITS_WMASK;
            end else if (paddr == MASK_ADDR) begin
                next_st.mask = pwdata[1:0];
            end
        end
        next_st.irq = |(next_st.status & next_st.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{fsm: CWC_IDLE, limits: LIMITS_RESET, status: STATUS_RESET, mask: MASK_RESET,
                    count: 8'h00, last_rise: 8'h00, tick_d: 1'b1, rdata: 32'h0, ready: 1'b0,
                    slverr: 1'b0, err: 1'b0, irq: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign prdata   = st.rdata;
    assign pready   = st.ready;
    assign pslverr  = st.slverr;
    assign wave_err = st.err;
    assign irq      = st.irq;

    ////////////////////////////////////////////////////////////////////////////
    // bit end as the fsm sees it: compare, measure load and status update happen here
    sequence s_rise_ok;
        st.fsm == CWC_LOW && line && (in_zero || in_one);
    endsequence

    sequence s_rise_bad;
        st.fsm == CWC_LOW && line && !in_zero && !in_one && st.limits[ENABLE_BIT];
    endsequence

    sequence s_bit_end;
        st.fsm == CWC_LOW && line;
    endsequence

    // line still low while the fsm measures
    sequence s_counting;
        st.fsm == CWC_LOW && !line;
    endsequence

    // a status read completing with no bit ending in the same cycle
    sequence s_clear_quiet;
        psel && penable && pready && !pwrite && paddr == STATUS_ADDR && !(st.fsm == CWC_LOW && line);
    endsequence

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_limit_write;
        psel && penable && pready && pwrite && paddr == LIMITS_ADDR;
    endsequence

    a_err_on_bad: assert property (@(posedge pclk) disable iff (!presetn)
        s_rise_bad |=> wave_err) else $error("bad rise not flagged");
    a_no_err_ok: assert property (@(posedge pclk) disable iff (!presetn)
        s_rise_ok |=> !wave_err) else $error("good rise flagged");
    a_err_disabled: assert property (@(posedge pclk) disable iff (!presetn)
        !st.limits[ENABLE_BIT] |=> !wave_err) else $error("error while disabled");
    a_err_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        wave_err |-> st.status[ST_WAVE_ERR]) else $error("status not set");

    // window edges checked through the comparators rather than by repeating the bound sums
    a_zero_latest: assert property (@(posedge pclk) disable iff (!presetn)
        st.count > ZERO_LATEST_BASE && (st.count - ZERO_LATEST_BASE) > {5'h0, st.limits[ZERO_LATEST_LSB +: 3]}
        |-> !in_zero) else $error("zero latest wrong");
    a_zero_early: assert property (@(posedge pclk) disable iff (!presetn)
        st.count < ZERO_EARLY_BASE && (ZERO_EARLY_BASE - st.count) > {5'h0, st.limits[ZERO_EARLY_LSB +: 3]}
        |-> !in_zero) else $error("zero earliest wrong");
    a_one_latest: assert property (@(posedge pclk) disable iff (!presetn)
        st.count > ONE_LATEST_BASE && (st.count - ONE_LATEST_BASE) > {5'h0, st.limits[ONE_LATEST_LSB +: 3]}
        |-> !in_one) else $error("one latest wrong");
    a_one_early: assert property (@(posedge pclk) disable iff (!presetn)
        st.count < ONE_EARLY_BASE && (ONE_EARLY_BASE - st.count) > {5'h0, st.limits[ONE_EARLY_LSB +: 3]}
        |-> !in_one) else $error("one earliest wrong");
    a_zero_nominal: assert property (@(posedge pclk) disable iff (!presetn)
        st.count >= ZERO_EARLY_BASE && st.count <= ZERO_LATEST_BASE |-> in_zero) else $error("zero base lost");
    a_one_nominal: assert property (@(posedge pclk) disable iff (!presetn)
        st.count >= ONE_EARLY_BASE && st.count <= ONE_LATEST_BASE |-> in_one) else $error("one base lost");

    // the count only ever steps by one tick, so a measured time cannot skip a window edge
    a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
        s_counting |=> st.count == $past(st.count) || st.count == $past(st.count) + 8'h01)
        else $error("count jumped");
    a_measure_load: assert property (@(posedge pclk) disable iff (!presetn)
        s_bit_end |=> st.last_rise == $past(st.count)) else $error("measure not loaded");

    // register bus: zero wait states, one-cycle answer
    a_limit_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_limit_write |=> st.limits == ($past(pwdata) & LIMITS_WMASK)) else $error("limits write lost");
    a_ready_setup: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup |=> pready) else $error("no ready after setup");
    a_ready_once: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("ready stood too long");
    a_slverr_map: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !mapped |=> pslverr) else $error("unmapped not refused");
    a_status_clear: assert property (@(posedge pclk) disable iff (!presetn)
        s_clear_quiet |=> st.status == 2'h0) else $error("status not cleared");
endmodule : cwc_checker

// ---- core/cwc_pkg.sv ----
// shared constants for the cec receive waveform checker
package cwc_pkg;
    // register byte offsets
    localparam logic [11:0] LIMITS_ADDR     = 12'h000;
    localparam logic [11:0] STATUS_ADDR     = 12'h004;
    localparam logic [11:0] MASK_ADDR       = 12'h008;
    localparam logic [11:0] MEASURE_ADDR    = 12'h00c;
    // limits register field positions
    localparam int          ZERO_LATEST_LSB = 20;
    localparam int          ZERO_EARLY_LSB  = 16;
    localparam int          ONE_LATEST_LSB  = 12;
    localparam int          ONE_EARLY_LSB   = 8;
    localparam int          ENABLE_BIT      = 0;
    localparam logic [31:0] LIMITS_RESET    = 32'h0000_0000;
    localparam logic [31:0] LIMITS_WMASK    = 32'h0077_7701;
    // status bits
    localparam int          ST_WAVE_ERR     = 0;
    localparam int          ST_BIT_DONE     = 1;
    localparam logic [1:0]  STATUS_RESET    = 2'h0;
    localparam logic [1:0]  MASK_RESET      = 2'h0;
    // window base figures in sample_clock periods
    localparam logic [7:0]  ZERO_LATEST_BASE = 8'h38;
    localparam logic [7:0]  ZERO_EARLY_BASE  = 8'h2b;
    localparam logic [7:0]  ONE_LATEST_BASE  = 8'h1a;
    localparam logic [7:0]  ONE_EARLY_BASE   = 8'h0d;
    localparam logic [7:0]  COUNT_MAX        = 8'hff;
    localparam int          SYNC_STAGES      = 3;
    typedef enum logic [0:0] {CWC_IDLE, CWC_LOW} cwc_state_t;
endpackage : cwc_pkg

// ---- core/cwc_sync.sv ----
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module cwc_sync (
    input  wire logic pclk,     // system clock
    input  wire logic presetn,  // async reset
    input  wire logic din,      // asynchronous input
    output logic      dout      // filtered level
);
    import cwc_pkg::*;
    typedef struct packed {
        logic [SYNC_STAGES-1:0] stage;
        logic                   level;
    } cwc_sync_t;
    cwc_sync_t st, next_st;
    always_comb begin
        next_st       = st;
        next_st.stage = {st.stage[SYNC_STAGES-2:0], din};
        // stage 0 feeds stage 1 only; stages 1 and 2 must agree
        if (st.stage[1] == st.stage[2]) begin
            next_st.level = st.stage[2];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{stage: {SYNC_STAGES{1'b1}}, level: 1'b1};
        end else begin
            st <= next_st;
        end
    end
    assign dout = st.level;
endmodule : cwc_sync

// ---- test/cwc_node.sv ----
// remote node model: drives one bit's low time and the sampling ticks
`timescale 1ns/1ps
module cwc_node (
    input  wire logic pclk,         // system clock
    output logic      cec_in,       // bus line, pulled up when released
    output logic      sample_clock  // sampling tick, still outside a bit
);
    initial begin
        cec_in       = 1'b1;
        sample_clock = 1'b0;
    end
    // margins before and after the ticks cover the input sync latency
    task automatic send_bit(input int n);
        cec_in <= 1'b0;
        repeat (8) @(posedge pclk);
        repeat (n) begin
            sample_clock <= 1'b1;
            repeat (4) @(posedge pclk);
            sample_clock <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        cec_in <= 1'b1;
        repeat (12) @(posedge pclk);
    endtask : send_bit
endmodule : cwc_node

// ---- test/testbench.sv ----
// self-checking bench for the cec receive waveform checker
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
module testbench;
    import cwc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, wave_err, irq, cec_in, sample_clock, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          num_errors, checks, pulses;
    cwc_checker i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_clock(sample_clock), .cec_in(cec_in), .wave_err(wave_err), .irq(irq));
    cwc_node i_node (.pclk(pclk), .cec_in(cec_in), .sample_clock(sample_clock));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) if (wave_err === 1'b1) pulses++;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            num_errors++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
        `CHK(err, 1'b0)
    endtask : chk_rd
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        chk_rd(LIMITS_ADDR, LIMITS_RESET);
        chk_rd(STATUS_ADDR, 32'h0);
        chk_rd(MASK_ADDR, 32'h0);
        apb(1'b1, LIMITS_ADDR, 32'hffff_ffff);
        chk_rd(LIMITS_ADDR, LIMITS_WMASK);
        apb(1'b0, 12'h010, 32'h0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0)
        $display("test regs done");
    endtask : t_regs
    // zero window 41..59, one window 9..27; probe each edge from both sides
    task automatic t_window();
        int  cnt[8] = '{8, 9, 27, 28, 40, 41, 59, 60};
        int  p;
        logic bad;
        apb(1'b1, LIMITS_ADDR, 32'h0032_1401);
        foreach (cnt[i]) begin
            bad = !((cnt[i] >= ZERO_EARLY_BASE - 2 && cnt[i] <= ZERO_LATEST_BASE + 3) ||
                    (cnt[i] >= ONE_EARLY_BASE - 4 && cnt[i] <= ONE_LATEST_BASE + 1));
            p = pulses;
            i_node.send_bit(cnt[i]);
            `CHK(pulses - p, int'(bad))
            chk_rd(STATUS_ADDR, {30'h0, 1'b1, bad});
            chk_rd(MEASURE_ADDR, 32'(cnt[i]));
        end
        $display("test window done");
    endtask : t_window
    task automatic t_disable();
        int p;
        apb(1'b1, LIMITS_ADDR, 32'h0032_1400);
        p = pulses;
        i_node.send_bit(5);
        `CHK(pulses - p, 0)
        chk_rd(STATUS_ADDR, 32'h2);
        $display("test disable done");
    endtask : t_disable
    task automatic t_irq();
        apb(1'b1, LIMITS_ADDR, 32'h0032_1401);
        apb(1'b1, MASK_ADDR, 32'h1);
        i_node.send_bit(5);
        `CHK(irq, 1'b1)
        chk_rd(STATUS_ADDR, 32'h3);
        `CHK(irq, 1'b0)
        apb(1'b1, MASK_ADDR, 32'h0);
        i_node.send_bit(5);
        `CHK(irq, 1'b0)
        chk_rd(STATUS_ADDR, 32'h3);
        $display("test irq done");
    endtask : t_irq
    // reset in mid-run with an interrupt pending: everything returns to its reset value
    task automatic t_reset();
        apb(1'b1, LIMITS_ADDR, 32'h0032_1401);
        apb(1'b1, MASK_ADDR, 32'h3);
        i_node.send_bit(5);
        `CHK(irq, 1'b1)
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        `CHK({pready, pslverr, wave_err, irq, prdata}, 36'h0)
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        `CHK(irq, 1'b0)
        chk_rd(LIMITS_ADDR, LIMITS_RESET);
        chk_rd(STATUS_ADDR, 32'h0);
        chk_rd(MASK_ADDR, 32'h0);
        $display("test reset done");
    endtask : t_reset
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    initial begin
        // the scenarios need a few thousand cycles; this leaves a wide margin
        #(40 * 20000);
        num_errors++;
        give_verdict();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_regs();
        t_window();
        t_disable();
        t_irq();
        t_reset();
        give_verdict();
    end
endmodule : testbench
